// >>> shared/opmode_consts.vh
`ifndef OPMODE_CONSTS_VH
`define OPMODE_CONSTS_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_DI_ASSIGN 8'h04
`define REG_LOCAL_SP 8'h08
`define REG_STATUS 8'h0c
`define REG_REMOTE_SP 8'h10

// control register fields
`define CTRL_RESET 32'h0000_0004
`define CTRL_INHIBIT 0
`define CTRL_ACK_PERMIT 1
`define CTRL_MAN_PERMIT 2
`define CTRL_TRACK 3
`define CTRL_PON_LO 4
`define CTRL_PON_HI 5
`define CTRL_RREQ 6
`define CTRL_MREQ 7
`define CTRL_TPL_LO 8
`define CTRL_TPL_HI 15
`define CTRL_USED 32'h0000_ffff

// discrete input assignment fields
`define DIA_RESET 32'h0000_0000
`define DIA_CODE_LO 0
`define DIA_CODE_HI 7
`define DIA_ACK_LO 8
`define DIA_ACK_HI 11
`define DIA_FM_LO 12
`define DIA_FM_HI 15
`define DIA_SEL_LO 16
`define DIA_SEL_HI 19
`define DIA_USED 32'h000f_ffff

// operating modes
`define MODE_AUTO 2'h0
`define MODE_REMOTE 2'h1
`define MODE_MANUAL 2'h2

// qualifying codes
`define TPL_ACK_A 8'h1e
`define TPL_ACK_B 8'h21
`define FUNC_REMOTE_ACK 8'h3c

// cycles to let the discrete input synchronisers fill after reset
`define SYNC_WAIT 2'h2
`define SP_RESET 16'h0000

`endif

// >>> hdl/di_sync.v
`timescale 1ns/1ps
`default_nettype none

module di_sync #(
    parameter WIDTH = 15
) (
    input wire clk_in,
    input wire rst_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    // first stage is read only by the second stage
    reg [WIDTH-1:0] stage1;

    always @(posedge clk_in) begin
        if (rst_in) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// >>> hdl/setpoint_tracker.v
`timescale 1ns/1ps
`default_nettype none
`include "opmode_consts.vh"

module setpoint_tracker #(
    parameter SP_WIDTH = 16
) (
    input wire clk_in,
    input wire rst_in,
    input wire wr_en_in,
    input wire [SP_WIDTH-1:0] wr_data_in,
    input wire [SP_WIDTH-1:0] remote_sp_in,
    input wire remote_src_in,
    input wire track_en_in,
    output reg [SP_WIDTH-1:0] local_sp_out
);

    reg src_q;
    reg [SP_WIDTH-1:0] saved_sp;
    wire enter_remote;
    wire leave_remote;

    assign enter_remote = remote_src_in & ~src_q;
    assign leave_remote = ~remote_src_in & src_q;

    always @(posedge clk_in) begin
        if (rst_in) begin
            src_q <= 1'b0;
            saved_sp <= `SP_RESET;
            local_sp_out <= `SP_RESET;
        end else begin
            src_q <= remote_src_in;
            if (enter_remote)
                saved_sp <= local_sp_out;
            // a change back to the local source wins over a software write in the same cycle
            if (leave_remote && track_en_in)
                local_sp_out <= remote_sp_in;
            else if (leave_remote)
                local_sp_out <= saved_sp;
            else if (wr_en_in)
                local_sp_out <= wr_data_in;
        end
    end

endmodule

`default_nettype wire

// >>> hdl/operating_mode_supervisor.v
// Operation
// - remote allowed only while remote inhibit off
// - inhibit ignores ack, selection, request, remote start
// - ack permit lets discrete input gate remote
// - ack needs template, permit, request, code sixty
// - auto-only setting refuses any entry to manual
// - manual prohibited ignores forced manual and start
// - start in the power-on mode setting
// - remote start inhibited: manual if forced, else auto
// - manual start prohibited: remote if acked, else auto
// - tracking on: remote to auto copies remote setpoint
// - tracking off: restore local setpoint saved earlier
// - manual source change remote-local tracks likewise
// - remote source change to local applies tracking
`timescale 1ns/1ps
`default_nettype none
`include "opmode_consts.vh"

module operating_mode_supervisor #(
    parameter DI_COUNT = 15,
    parameter SP_WIDTH = 16
) (
    input wire clk_in,
    input wire rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    input wire [DI_COUNT-1:0] discrete_input_in,
    input wire [SP_WIDTH-1:0] remote_setpoint_in,
    output reg [1:0] mode_out,
    output reg setpoint_remote_out,
    output reg [SP_WIDTH-1:0] setpoint_out,
    output wire [SP_WIDTH-1:0] local_setpoint_out
);

    localparam ST_INIT = 2'h0;
    localparam ST_RUN = 2'h1;

    reg [31:0] ctrl;
    reg [31:0] di_assign;
    reg [1:0] phase;
    reg [1:0] wait_cnt;
    reg [1:0] mode;
    reg [1:0] next_mode;
    reg [31:0] rdata;
    reg addr_ok;
    reg pon_manual;

    wire [DI_COUNT-1:0] di_sync;
    wire remote_inhibit;
    wire remote_ack_permit;
    wire manual_permit_select;
    wire setpoint_track_enable;
    wire [1:0] power_on_mode;
    wire remote_request_param;
    wire manual_request;
    wire [7:0] control_template;
    wire [7:0] ack_code;
    wire ack_di;
    wire forced_manual;
    wire sel_di;
    wire remote_request;
    wire ack_active;
    wire want_remote;
    wire manual_ok;
    wire remote_src;
    wire setup;
    wire access;
    wire wr_local;
    wire wr_ctrl;
    wire manual_demand;

    // picks the discrete input assigned to a function; slot 0 means none
    function di_slot;
        input [DI_COUNT-1:0] di;
        input [3:0] slot;
        integer i;
        begin
            di_slot = 1'b0;
            for (i = 1; i <= DI_COUNT; i = i + 1) begin
                if (slot == i[3:0])
                    di_slot = di[i-1];
            end
        end
    endfunction

    di_sync #(
        .WIDTH(DI_COUNT)
    ) u_di_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(discrete_input_in),
        .sync_out(di_sync)
    );

    assign remote_inhibit = ctrl[`CTRL_INHIBIT];
    assign remote_ack_permit = ctrl[`CTRL_ACK_PERMIT];
    assign manual_permit_select = ctrl[`CTRL_MAN_PERMIT];
    assign setpoint_track_enable = ctrl[`CTRL_TRACK];
    assign power_on_mode = ctrl[`CTRL_PON_HI:`CTRL_PON_LO];
    assign remote_request_param = ctrl[`CTRL_RREQ];
    assign manual_request = ctrl[`CTRL_MREQ];
    assign control_template = ctrl[`CTRL_TPL_HI:`CTRL_TPL_LO];
    assign ack_code = di_assign[`DIA_CODE_HI:`DIA_CODE_LO];

    assign ack_di = di_slot(di_sync, di_assign[`DIA_ACK_HI:`DIA_ACK_LO]);
    assign forced_manual = di_slot(di_sync, di_assign[`DIA_FM_HI:`DIA_FM_LO]);
    assign sel_di = di_slot(di_sync, di_assign[`DIA_SEL_HI:`DIA_SEL_LO]);

    // request and discrete selection count for nothing under inhibit
    assign remote_request = ~remote_inhibit &
        (remote_request_param | sel_di);

    // acknowledge function qualifies only with every condition present
    assign ack_active = ~remote_inhibit & remote_ack_permit &
        remote_request_param &
        ((control_template == `TPL_ACK_A) |
         (control_template == `TPL_ACK_B)) &
        (ack_code == `FUNC_REMOTE_ACK) &
        (di_assign[`DIA_ACK_HI:`DIA_ACK_LO] != 4'h0);

    // with the function active the input decides, otherwise the request;
    // the inhibit value leaves the input without effect
    assign want_remote = ~remote_inhibit &
        (ack_active ? ack_di : remote_request);

    assign manual_ok = manual_permit_select;

    // a manual start is held like an operator request until the next
    // control word, otherwise it would last a single cycle
    assign manual_demand = manual_request | forced_manual |
        pon_manual;

    always @* begin
        next_mode = mode;
        if (phase == ST_INIT) begin
            case (power_on_mode)
                `MODE_REMOTE: begin
                    if (!remote_inhibit)
                        next_mode = `MODE_REMOTE;
                    else if (forced_manual && manual_ok)
                        next_mode = `MODE_MANUAL;
                    else
                        next_mode = `MODE_AUTO;
                end
                `MODE_MANUAL: begin
                    if (manual_ok)
                        next_mode = `MODE_MANUAL;
                    else if (!remote_inhibit && ack_di &&
                             remote_request_param)
                        next_mode = `MODE_REMOTE;
                    else
                        next_mode = `MODE_AUTO;
                end
                default: begin
                    next_mode = `MODE_AUTO;
                end
            endcase
        end else begin
            case (mode)
                `MODE_AUTO: begin
                    if (manual_ok && manual_demand)
                        next_mode = `MODE_MANUAL;
                    else if (want_remote)
                        next_mode = `MODE_REMOTE;
                end
                `MODE_REMOTE: begin
                    if (manual_ok && manual_demand)
                        next_mode = `MODE_MANUAL;
                    else if (!want_remote)
                        next_mode = `MODE_AUTO;
                end
                `MODE_MANUAL: begin
                    // leaving manual lands where the remote request points
                    if (!manual_ok || !manual_demand)
                        next_mode = want_remote ? `MODE_REMOTE :
                            `MODE_AUTO;
                end
                default: begin
                    next_mode = `MODE_AUTO;
                end
            endcase
        end
    end

    // waits for the synchronisers to hold real input levels first
    always @(posedge clk_in) begin
        if (rst_in) begin
            phase <= ST_INIT;
            wait_cnt <= 2'h0;
            pon_manual <= 1'b0;
            mode <= `MODE_AUTO;
        end else begin
            case (phase)
                ST_INIT: begin
                    if (wait_cnt == `SYNC_WAIT) begin
                        phase <= ST_RUN;
                        mode <= next_mode;
                        pon_manual <= next_mode == `MODE_MANUAL;
                    end else begin
                        wait_cnt <= wait_cnt + 2'h1;
                    end
                end
                ST_RUN: begin
                    mode <= next_mode;
                    // a new control word hands the choice back to the request
                    if (wr_ctrl || !manual_ok)
                        pon_manual <= 1'b0;
                end
                default: begin
                    phase <= ST_INIT;
                end
            endcase
        end
    end

    // the remote setpoint is in force in remote mode, and in manual while
    // the source still selects remote
    assign remote_src = (phase == ST_RUN) &&
        ((mode == `MODE_REMOTE) ||
         ((mode == `MODE_MANUAL) && want_remote));

    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in;
    assign wr_local = access & pwrite_in & (paddr_in == `REG_LOCAL_SP);
    assign wr_ctrl = access & pwrite_in & (paddr_in == `REG_CTRL);

    setpoint_tracker #(
        .SP_WIDTH(SP_WIDTH)
    ) u_tracker (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_en_in(wr_local),
        .wr_data_in(pwdata_in[SP_WIDTH-1:0]),
        .remote_sp_in(remote_setpoint_in),
        .remote_src_in(remote_src),
        .track_en_in(setpoint_track_enable),
        .local_sp_out(local_setpoint_out)
    );

    always @* begin
        addr_ok = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr_in)
            `REG_CTRL: rdata = ctrl;
            `REG_DI_ASSIGN: rdata = di_assign;
            `REG_LOCAL_SP: rdata[SP_WIDTH-1:0] = local_setpoint_out;
            `REG_STATUS: begin
                rdata[1:0] = mode;
                rdata[2] = remote_src;
                rdata[3] = ack_active;
                rdata[4] = want_remote;
                rdata[5] = phase == ST_RUN;
                rdata[6] = pon_manual;
                rdata[31:16] = setpoint_out;
            end
            `REG_REMOTE_SP: rdata[SP_WIDTH-1:0] = remote_setpoint_in;
            default: addr_ok = 1'b0;
        endcase
    end

    // zero wait states: read data is latched in the setup cycle
    assign pready_out = 1'b1;
    assign pslverr_out = access & ~addr_ok;

    always @(posedge clk_in) begin
        if (rst_in) begin
            ctrl <= `CTRL_RESET;
            di_assign <= `DIA_RESET;
            prdata_out <= 32'h0000_0000;
        end else begin
            if (setup && !pwrite_in)
                prdata_out <= rdata;
            if (access && pwrite_in && paddr_in == `REG_CTRL)
                ctrl <= pwdata_in & `CTRL_USED;
            if (access && pwrite_in && paddr_in == `REG_DI_ASSIGN)
                di_assign <= pwdata_in & `DIA_USED;
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            mode_out <= `MODE_AUTO;
            setpoint_remote_out <= 1'b0;
            setpoint_out <= `SP_RESET;
        end else begin
            mode_out <= mode;
            setpoint_remote_out <= remote_src;
            setpoint_out <= remote_src ? remote_setpoint_in :
                local_setpoint_out;
        end
    end

endmodule

`default_nettype wire

// >>> tb/opmode_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "opmode_consts.vh"
module opmode_monitor #(
    parameter DI_COUNT = 15,
    parameter SP_WIDTH = 16
) (
    input wire clk_in,
    input wire rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pslverr_out,
    input wire [SP_WIDTH-1:0] remote_setpoint_in,
    input wire [1:0] mode_out,
    input wire setpoint_remote_out,
    input wire [SP_WIDTH-1:0] setpoint_out,
    input wire [SP_WIDTH-1:0] local_setpoint_out
);
    reg [31:0] ctrl;
    reg [SP_WIDTH-1:0] saved;
    wire acc = psel_in && penable_in;
    wire mapped = paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    // shadow of the control word, so rules can be judged from the bus
    always @(posedge clk_in) begin
        if (rst_in)
            ctrl <= `CTRL_RESET;
        else if (acc && pwrite_in && paddr_in == `REG_CTRL)
            ctrl <= pwdata_in;
        if ($rose(setpoint_remote_out))
            saved <= local_setpoint_out;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence src_left;
        $fell(setpoint_remote_out);
    endsequence
    a_error_unmapped: assert property (acc |-> pslverr_out == !mapped)
        else $error("slave error wrong");
    a_mode_legal: assert property (mode_out != 2'h3)
        else $error("illegal mode");
    a_inhibit_remote: assert property
        ((ctrl[`CTRL_INHIBIT]) [*4] |-> mode_out != `MODE_REMOTE)
        else $error("remote while inhibited");
    a_auto_only: assert property
        ((!ctrl[`CTRL_MAN_PERMIT]) [*4] |-> mode_out != `MODE_MANUAL)
        else $error("manual while prohibited");
    a_remote_source: assert property
        ((mode_out == `MODE_REMOTE) [*3] |-> setpoint_remote_out)
        else $error("remote mode without remote source");
    a_remote_value: assert property
        ((setpoint_remote_out && $stable(remote_setpoint_in)) [*3]
        |-> setpoint_out == remote_setpoint_in)
        else $error("setpoint not remote");
    a_local_value: assert property
        ((!setpoint_remote_out && $stable(local_setpoint_out)) [*3]
        |-> setpoint_out == local_setpoint_out)
        else $error("setpoint not local");
    a_track_copy: assert property (src_left ##0 ctrl[`CTRL_TRACK]
        |-> ##[0:2] local_setpoint_out == remote_setpoint_in)
        else $error("no tracking copy");
    a_track_restore: assert property
        (src_left ##0 !ctrl[`CTRL_TRACK]
        |-> ##[0:2] local_setpoint_out == saved)
        else $error("local not restored");
endmodule
bind operating_mode_supervisor opmode_monitor #(
    .DI_COUNT(DI_COUNT),
    .SP_WIDTH(SP_WIDTH)
) mon_u (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pslverr_out, .remote_setpoint_in, .mode_out,
    .setpoint_remote_out, .setpoint_out, .local_setpoint_out);
`default_nettype wire

// >>> tb/di_source.sv
`timescale 1ns/1ps
`default_nettype none
module di_source #(
    parameter ACK_BIT = 2,
    parameter FM_BIT = 4
) (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic ack_in,
    input wire logic fm_in,
    input wire logic [15:0] sp_in,
    output logic [14:0] di_out,
    output logic [15:0] sp_out
);
    logic [1:0] held = 2'h0;
    initial di_out = 15'h0;
    initial sp_out = 16'h0;
    // slow contacts show each change one cycle late
    always @(posedge clk_in) begin
        held <= {fm_in, ack_in};
        di_out[ACK_BIT] <= slow_in ? held[0] : ack_in;
        di_out[FM_BIT] <= slow_in ? held[1] : fm_in;
        sp_out <= sp_in;
    end
endmodule
`default_nettype wire

// >>> tb/operating_mode_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "opmode_consts.vh"
`define CMP(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module operating_mode_supervisor_bench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, got;
    logic pready, pslverr, src;
    logic ack = 1'b0;
    logic fm = 1'b0;
    logic slow = 1'b0;
    logic [14:0] di;
    logic [15:0] rsp = 16'h0;
    logic [15:0] rsp_q, sp, lsp, lval;
    logic [1:0] mode;
    logic [63:0] exp_q[$];
    logic [63:0] cur;
    int num_errors = 0;
    int checks_done = 0;
    event seen;

    always #25 clk_in = ~clk_in;

    operating_mode_supervisor dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .discrete_input_in(di),
        .remote_setpoint_in(rsp_q), .mode_out(mode),
        .setpoint_remote_out(src), .setpoint_out(sp),
        .local_setpoint_out(lsp));
    di_source part_u (.clk_in(clk_in), .slow_in(slow), .ack_in(ack),
        .fm_in(fm), .sp_in(rsp), .di_out(di), .sp_out(rsp_q));

    task test_done;
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // idle edge at the end keeps back-to-back calls from double driving
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        got = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        exp_q.push_back({e & m, m});
        apb(1'b0, a, 32'h0);
        ->seen;
    endtask
    task automatic st(input logic [1:0] m, input logic s);
        rd(`REG_STATUS, {29'h0, s, m}, 32'h7);
    endtask
    task automatic step(input logic a, input logic f);
        ack <= a;
        fm <= f;
        repeat (8) @(posedge clk_in);
    endtask
    // control must land before the power-on decision, third edge
    task automatic pon(input logic [31:0] c, input logic [1:0] m);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        apb(1'b1, `REG_CTRL, c);
        repeat (4) @(posedge clk_in);
        st(m, m == `MODE_REMOTE);
    endtask
    always @(seen) begin
        cur = exp_q.pop_front();
        `CMP(got & cur[31:0], cur[63:32])
    end
    initial begin
        #200us;
        num_errors++;
        test_done;
    end
    initial begin
        static logic [31:0] pc[5] = '{32'h4, 32'h50, 32'h24, 32'h51, 32'h20};
        static logic [1:0] pm[5] = '{`MODE_AUTO, `MODE_REMOTE, `MODE_MANUAL,
            `MODE_AUTO, `MODE_AUTO};
        got = $urandom(11);
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(`REG_CTRL, `CTRL_RESET, 32'hffff_ffff);
        rd(`REG_DI_ASSIGN, `DIA_RESET, 32'hffff_ffff);
        rd(8'h14, 32'h0, 32'hffff_ffff);
        for (int i = 0; i < 5; i++)
            pon(pc[i], pm[i]);
        lval = 16'($urandom);
        rsp <= 16'($urandom);
        apb(1'b1, `REG_DI_ASSIGN, 32'h0007_533c);
        apb(1'b1, `REG_LOCAL_SP, {16'h0, lval});
        apb(1'b1, `REG_CTRL, 32'h0000_1e4e);
        step(1'b1, 1'b0);
        rd(`REG_STATUS, {rsp, 16'h5}, 32'hffff_0007);
        step(1'b0, 1'b0);
        st(`MODE_AUTO, 1'b0);
        rd(`REG_LOCAL_SP, {16'h0, rsp}, 32'hffff);
        slow <= 1'b1;
        apb(1'b1, `REG_LOCAL_SP, {16'h0, lval});
        apb(1'b1, `REG_CTRL, 32'h0000_2146);
        step(1'b1, 1'b0);
        st(`MODE_REMOTE, 1'b1);
        apb(1'b1, `REG_LOCAL_SP, {16'h0, ~lval});
        step(1'b0, 1'b0);
        rd(`REG_LOCAL_SP, {16'h0, lval}, 32'hffff);
        apb(1'b1, `REG_CTRL, 32'h0000_214e);
        step(1'b1, 1'b1);
        st(`MODE_MANUAL, 1'b1);
        step(1'b0, 1'b1);
        st(`MODE_MANUAL, 1'b0);
        rd(`REG_LOCAL_SP, {16'h0, rsp}, 32'hffff);
        apb(1'b1, `REG_CTRL, 32'h0000_1e4f);
        step(1'b1, 1'b0);
        st(`MODE_AUTO, 1'b0);
        apb(1'b1, `REG_CTRL, 32'h0000_1e4a);
        step(1'b0, 1'b1);
        st(`MODE_AUTO, 1'b0);
        apb(1'b1, `REG_CTRL, 32'h0000_1e4e);
        step(1'b0, 1'b1);
        st(`MODE_MANUAL, 1'b0);
        apb(1'b1, `REG_CTRL, 32'h0000_1e0c);
        step(1'b1, 1'b0);
        st(`MODE_AUTO, 1'b0);
        apb(1'b1, `REG_CTRL, 32'h0000_1e8c);
        step(1'b0, 1'b0);
        st(`MODE_MANUAL, 1'b0);
        apb(1'b1, 8'h20, 32'hffff_ffff);
        rd(`REG_CTRL, 32'h0000_1e8c, 32'hffff);
        @(posedge clk_in);
        test_done;
    end
endmodule
`default_nettype wire
